// ===== rtl/cpu_memory_space_decoder.sv
// program and internal data memory decoder for an 8-bit core
// assumes requests and answers synchronous to clk_sys, one access per cycle
// Functional notes
// - 64 kB code space, flash from zero
// - code writable only by external move plus enable
// - 256 bytes data RAM, 0x00 to 0xFF
// - lower 128 bytes reached direct or indirect
// - above 0x7F: direct to registers, indirect RAM
// - four banks at 0x00-0x1F, status bits pick
// - indirect address from bank register 0 or 1
// - bits 0x00-0x7F map to bytes 0x20-0x2F
// - bit versus byte chosen by instruction type
// - push writes at pointer plus one, increments
// - pointer resets to 0x07
// - stack reaches all 256 RAM bytes
// - stack pointer is register at 0x81
// - direct 0x80-0xFF reaches register space
// - registers ending 0x0/0x8 are bit addressable
module cpu_memory_space_decoder
   import mem_space_pkg::*;
#(
   parameter bit BIG_FLASH = 1'h1
) (
   input  wire logic      clk_sys,
   input  wire logic      rstn,
   input  wire data_req_s dreq,
   output logic [7:0]     drdata,
   output logic           drbit,
   output logic           reg_space_sel,
   output logic           reg_space_ok,
   input  wire prog_req_s preq,
   output logic [7:0]     prdata,
   output logic           pwrite_done,
   output logic           prog_in_flash,
   output logic [7:0]     stack_pointer,
   output logic [1:0]     active_bank
);

   logic [7:0] ram [RAM_WORDS];
   logic [7:0] flash [FLASH_WORDS];

   logic [7:0] stack_pointer_reg;
   logic [7:0] stack_pointer_next;
   logic [7:0] program_store_control_reg;
   logic [7:0] cpu_status_word_reg;

   // bit address decode, shared by read and write paths
   function automatic logic [7:0] bit_byte(input logic [7:0] baddr);
      return baddr[7] ? {baddr[7:3], 3'h0}
                      : BIT_BYTE_BASE + {4'h0, baddr[6:3]};
   endfunction

   wire logic [1:0] bank = {cpu_status_word_reg[BANK_SEL_HI_BIT],
                            cpu_status_word_reg[BANK_SEL_LO_BIT]};
   wire logic [7:0] idx_loc = {3'h0, bank, 2'h0, dreq.ind_sel};
   wire logic [7:0] ind_addr = ram[idx_loc];
   wire logic       is_bit = (dreq.kind == ACC_BIT);
   wire logic [7:0] byte_addr = is_bit ? bit_byte(dreq.addr) : dreq.addr;
   wire logic [2:0] bit_pos = dreq.addr[2:0];
   wire logic       direct_like = (dreq.kind == ACC_DIRECT) || is_bit;
   wire logic       hits_regs = direct_like && (byte_addr > LOWER_TOP);
   wire logic       bit_reg_ok = (byte_addr[2:0] == 3'h0);
   wire logic [7:0] push_addr = stack_pointer_reg + 8'h01;
   wire logic [7:0] ram_addr =
      (dreq.kind == ACC_INDIRECT) ? ind_addr :
      (dreq.kind == ACC_PUSH)     ? push_addr :
      (dreq.kind == ACC_POP)      ? stack_pointer_reg :
      byte_addr;
   wire logic       ram_en = (dreq.kind != ACC_NONE) && !hits_regs;
   wire logic       regs_en = hits_regs && (!is_bit || bit_reg_ok);

   // register file read mux; unoccupied addresses read zero
   wire logic [7:0] regs_rd =
      (byte_addr == PTR_ADDR)       ? stack_pointer_reg :
      (byte_addr == STORE_CTL_ADDR) ? program_store_control_reg :
      (byte_addr == STATUS_ADDR)    ? cpu_status_word_reg : 8'h00;
   wire logic [7:0] cur_byte = hits_regs ? regs_rd : ram[ram_addr];
   wire logic [7:0] bit_merged = cur_byte & ~(8'h01 << bit_pos)
                                 | ({7'h00, dreq.wbit} << bit_pos);
   wire logic [7:0] wr_byte = is_bit ? bit_merged : dreq.wdata;
   // pop never writes; push always writes, whatever its write flag
   wire logic       dwr = (dreq.write && (dreq.kind != ACC_POP))
                          || (dreq.kind == ACC_PUSH);

   // stack pointer update; push and pop take priority over a direct write
   always_comb begin
      stack_pointer_next = stack_pointer_reg;
      if (dreq.kind == ACC_PUSH)
         stack_pointer_next = push_addr;
      else if (dreq.kind == ACC_POP)
         stack_pointer_next = stack_pointer_reg - 8'h01;
      else if (regs_en && dwr && byte_addr == PTR_ADDR)
         stack_pointer_next = wr_byte;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         stack_pointer_reg         <= PTR_RESET;
         program_store_control_reg <= STORE_CTL_RESET;
         cpu_status_word_reg       <= STATUS_RESET;
      end else begin
         stack_pointer_reg <= stack_pointer_next;
         if (regs_en && dwr && byte_addr == STORE_CTL_ADDR)
            program_store_control_reg <= wr_byte;
         if (regs_en && dwr && byte_addr == STATUS_ADDR)
            cpu_status_word_reg <= wr_byte;
      end
   end

   // data RAM, no reset on contents
   always_ff @(posedge clk_sys) begin
      if (ram_en && dwr)
         ram[ram_addr] <= wr_byte;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         drdata <= 8'h00;
         drbit  <= 1'h0;
      end else begin
         drdata <= cur_byte;
         drbit  <= cur_byte[bit_pos];
      end
   end

   assign reg_space_sel = hits_regs;
   assign reg_space_ok  = regs_en;

   // program space: flash from zero, rest of 64 kB reads 0xFF
   wire logic [15:0] flash_top = BIG_FLASH ? FLASH_TOP_BIG : FLASH_TOP_SMALL;
   wire logic        in_flash = (preq.addr <= flash_top);
   wire logic        pwr_ok = preq.valid && preq.write && preq.ext_move
                              && program_store_control_reg[STORE_WEN_BIT]
                              && in_flash;
   wire logic [13:0] faddr = preq.addr[13:0];

   always_ff @(posedge clk_sys) begin
      if (pwr_ok)
         flash[faddr] <= preq.wdata;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prdata      <= 8'h00;
         pwrite_done <= 1'h0;
      end else begin
         prdata      <= in_flash ? flash[faddr] : 8'hFF;
         pwrite_done <= pwr_ok;
      end
   end

   assign prog_in_flash = in_flash;
   assign stack_pointer = stack_pointer_reg;
   assign active_bank   = bank;

   property p_push_sp;
      @(posedge clk_sys) disable iff (!rstn)
      dreq.kind == ACC_PUSH |=> stack_pointer == $past(stack_pointer) + 8'h01;
   endproperty
   a_push_sp: assert property (p_push_sp) else $error("push did not bump pointer");

   property p_pop_sp;
      @(posedge clk_sys) disable iff (!rstn)
      dreq.kind == ACC_POP |=> stack_pointer == $past(stack_pointer) - 8'h01;
   endproperty
   a_pop_sp: assert property (p_pop_sp) else $error("pop did not drop pointer");

   property p_sp_reset;
      @(posedge clk_sys) $rose(rstn) |-> stack_pointer == PTR_RESET;
   endproperty
   a_sp_reset: assert property (p_sp_reset) else $error("pointer not 0x07 at reset");

   property p_direct_high_regs;
      @(posedge clk_sys) disable iff (!rstn)
      (dreq.kind == ACC_DIRECT && dreq.addr[7]) |-> reg_space_sel;
   endproperty
   a_direct_high_regs: assert property (p_direct_high_regs) else $error("direct high missed");

   property p_indirect_ram;
      @(posedge clk_sys) disable iff (!rstn)
      dreq.kind == ACC_INDIRECT |-> !reg_space_sel;
   endproperty
   a_indirect_ram: assert property (p_indirect_ram) else $error("indirect hit registers");

   property p_low_direct_ram;
      @(posedge clk_sys) disable iff (!rstn)
      (dreq.kind == ACC_DIRECT && !dreq.addr[7]) |-> !reg_space_sel;
   endproperty
   a_low_direct_ram: assert property (p_low_direct_ram) else $error("low direct hit registers");

   property p_high_bit_reg;
      @(posedge clk_sys) disable iff (!rstn)
      (is_bit && dreq.addr[7]) |-> reg_space_ok && byte_addr[2:0] == 3'h0
                                   && byte_addr[7:3] == dreq.addr[7:3];
   endproperty
   a_high_bit_reg: assert property (p_high_bit_reg) else $error("high bit not bit addressable");

   property p_low_bit_ram;
      @(posedge clk_sys) disable iff (!rstn)
      (is_bit && !dreq.addr[7]) |-> (!reg_space_sel && byte_addr[7:4] == 4'h2);
   endproperty
   a_low_bit_ram: assert property (p_low_bit_ram) else $error("low bit outside 0x20-0x2F");

   property p_prog_write;
      @(posedge clk_sys) disable iff (!rstn)
      pwrite_done |-> $past(program_store_control_reg[STORE_WEN_BIT])
                      && $past(preq.ext_move);
   endproperty
   a_prog_write: assert property (p_prog_write) else $error("code write without enable");

   property p_bank;
      @(posedge clk_sys) disable iff (!rstn)
      active_bank == {cpu_status_word_reg[BANK_SEL_HI_BIT], cpu_status_word_reg[BANK_SEL_LO_BIT]};
   endproperty
   a_bank: assert property (p_bank) else $error("bank select mismatch");

   property p_push_addr;
      @(posedge clk_sys) disable iff (!rstn)
      dreq.kind == ACC_PUSH |-> ram_en && dwr && ram_addr == stack_pointer + 8'h01;
   endproperty
   a_push_addr: assert property (p_push_addr) else $error("push not written above pointer");

   property p_pop_addr;
      @(posedge clk_sys) disable iff (!rstn)
      dreq.kind == ACC_POP |-> ram_en && !dwr && ram_addr == stack_pointer;
   endproperty
   a_pop_addr: assert property (p_pop_addr) else $error("pop not read at pointer");

   property p_ptr_hold;
      @(posedge clk_sys) disable iff (!rstn)
      dreq.kind == ACC_NONE |=> $stable(stack_pointer);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved while idle");

   property p_stack_top;
      @(posedge clk_sys) disable iff (!rstn)
      (dreq.kind == ACC_PUSH && stack_pointer == 8'hFE) |-> ram_addr == 8'hFF && ram_en;
   endproperty
   a_stack_top: assert property (p_stack_top) else $error("stack cannot reach top byte");

   property p_ind_index;
      @(posedge clk_sys) disable iff (!rstn)
      dreq.kind == ACC_INDIRECT |->
         ram_addr == ram[{3'h0, active_bank, 3'h0} | {7'h00, dreq.ind_sel}];
   endproperty
   a_ind_index: assert property (p_ind_index) else $error("indirect index register wrong");

   property p_ind_upper_ram;
      @(posedge clk_sys) disable iff (!rstn)
      dreq.kind == ACC_INDIRECT |-> ram_en && !regs_en;
   endproperty
   a_ind_upper_ram: assert property (p_ind_upper_ram) else $error("indirect not to RAM");

   property p_direct_low_addr;
      @(posedge clk_sys) disable iff (!rstn)
      (dreq.kind == ACC_DIRECT && !dreq.addr[7]) |-> ram_en && ram_addr == dreq.addr;
   endproperty
   a_direct_low_addr: assert property (p_direct_low_addr) else $error("low direct address moved");

   property p_ptr_read;
      @(posedge clk_sys) disable iff (!rstn)
      (dreq.kind == ACC_DIRECT && !dreq.write && dreq.addr == PTR_ADDR)
         |=> drdata == $past(stack_pointer);
   endproperty
   a_ptr_read: assert property (p_ptr_read) else $error("pointer read wrong");

   property p_ptr_write;
      @(posedge clk_sys) disable iff (!rstn)
      (dreq.kind == ACC_DIRECT && dreq.write && dreq.addr == PTR_ADDR)
         |=> stack_pointer == $past(dreq.wdata);
   endproperty
   a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");

   property p_status_byte;
      @(posedge clk_sys) disable iff (!rstn)
      (dreq.kind == ACC_DIRECT && dreq.write && dreq.addr == STATUS_ADDR)
         |=> cpu_status_word_reg == $past(dreq.wdata);
   endproperty
   a_status_byte: assert property (p_status_byte) else $error("byte write not whole byte");

   property p_bit_status;
      @(posedge clk_sys) disable iff (!rstn)
      (is_bit && dreq.write && byte_addr == STATUS_ADDR)
         |=> cpu_status_word_reg[$past(dreq.addr[2:0])] == $past(dreq.wbit);
   endproperty
   a_bit_status: assert property (p_bit_status) else $error("register bit write lost");

   property p_bit_pos;
      @(posedge clk_sys) disable iff (!rstn)
      is_bit |=> drbit == drdata[$past(dreq.addr[2:0])];
   endproperty
   a_bit_pos: assert property (p_bit_pos) else $error("bit position wrong");

   property p_flash_low;
      @(posedge clk_sys) disable iff (!rstn)
      (preq.valid && preq.addr <= FLASH_TOP_SMALL) |-> prog_in_flash;
   endproperty
   a_flash_low: assert property (p_flash_low) else $error("low code address not flash");

   property p_flash_high;
      @(posedge clk_sys) disable iff (!rstn)
      (preq.valid && preq.addr > FLASH_TOP_BIG) |-> !prog_in_flash;
   endproperty
   a_flash_high: assert property (p_flash_high) else $error("high code address in flash");

   property p_outside_ff;
      @(posedge clk_sys) disable iff (!rstn)
      (preq.valid && !prog_in_flash) |=> prdata == 8'hFF;
   endproperty
   a_outside_ff: assert property (p_outside_ff) else $error("outside flash not 0xFF");

   property p_no_code_write;
      @(posedge clk_sys) disable iff (!rstn)
      (preq.valid && preq.write && !preq.ext_move) |=> !pwrite_done;
   endproperty
   a_no_code_write: assert property (p_no_code_write) else $error("plain code write done");

endmodule // cpu_memory_space_decoder

// ===== rtl/mem_space_pkg.sv
// memory space decoder constants and carrier types
// assumes a single core clock domain; shared by design and bench
package mem_space_pkg;
   localparam logic [7:0]  PTR_ADDR       = 8'h81;
   localparam logic [7:0]  STORE_CTL_ADDR = 8'h8F;
   localparam logic [7:0]  STATUS_ADDR    = 8'hD0;
   localparam logic [7:0]  PTR_RESET      = 8'h07;
   localparam logic [7:0]  STATUS_RESET   = 8'h00;
   localparam logic [7:0]  STORE_CTL_RESET = 8'h00;
   localparam int          STORE_WEN_BIT  = 0;
   localparam int          BANK_SEL_LO_BIT = 3;
   localparam int          BANK_SEL_HI_BIT = 4;
   localparam logic [7:0]  LOWER_TOP      = 8'h7F;
   localparam logic [7:0]  BIT_BYTE_BASE  = 8'h20;
   localparam logic [15:0] FLASH_TOP_BIG  = 16'h3FFF;
   localparam logic [15:0] FLASH_TOP_SMALL = 16'h1FFF;
   localparam logic [15:0] FLASH_RSVD_BIG = 16'h3E00;
   localparam int          FLASH_WORDS    = 16384;
   localparam int          RAM_WORDS      = 256;

   typedef enum logic [2:0] {
      ACC_NONE,
      ACC_DIRECT,
      ACC_INDIRECT,
      ACC_BIT,
      ACC_PUSH,
      ACC_POP
   } acc_kind_e;

   // one data access from the core
   typedef struct packed {
      acc_kind_e   kind;
      logic        write;
      logic        ind_sel;
      logic [7:0]  addr;
      logic [7:0]  wdata;
      logic        wbit;
   } data_req_s;

   // one program memory access from the core
   typedef struct packed {
      logic        valid;
      logic        ext_move;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } prog_req_s;
endpackage : mem_space_pkg

// ===== verification/core_model.sv
// core-side model: issues data and program accesses to the decoder
// assumes clk_sys from the bench; requests change at falling edges
module core_model
   import mem_space_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic reg_space_sel,
   input  wire logic reg_space_ok,
   input  wire logic prog_in_flash,
   output data_req_s dreq,
   output prog_req_s preq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sel_seen;
   logic ok_seen;
   logic flash_seen;
   initial begin
      dreq = '0;
      preq = '0;
   end
   // one data access, held over one rising edge
   // any 8-bit address is issued, occupied register or not
   task automatic acc(input acc_kind_e k, input logic w, input logic s,
                      input logic [7:0] a, input logic [7:0] d, input logic b);
      @(negedge clk_sys);
      dreq = '{kind: k, write: w, ind_sel: s, addr: a, wdata: d, wbit: b};
      #1;
      sel_seen = reg_space_sel;
      ok_seen  = reg_space_ok;
      @(negedge clk_sys);
      dreq = '0;
   endtask
   // one code access, held over one rising edge; any 16-bit address is issued
   task automatic prog(input logic w, input logic x, input logic [15:0] a,
                       input logic [7:0] d);
      @(negedge clk_sys);
      preq = '{valid: 1'h1, ext_move: x, write: w, addr: a, wdata: d};
      #1;
      flash_seen = prog_in_flash;
      @(negedge clk_sys);
      preq = '0;
   endtask
endmodule // core_model

// ===== verification/cpu_memory_space_decoder_test.sv
// self-checking bench for the memory space decoder
// assumes the core model drives all requests; large flash variant
module cpu_memory_space_decoder_test;
   import mem_space_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys = 1'h0;
   logic       rstn = 1'h0;
   data_req_s  dreq;
   prog_req_s  preq;
   logic [7:0] drdata;
   logic [7:0] prdata;
   logic [7:0] stack_pointer;
   logic       drbit;
   logic       reg_space_sel;
   logic       reg_space_ok;
   logic       pwrite_done;
   logic       prog_in_flash;
   logic [1:0] active_bank;
   int         err_total = 0;
   int         comparisons = 0;
   int         cycles = 0;
   always #2 clk_sys = ~clk_sys;
   cpu_memory_space_decoder #(.BIG_FLASH(1'h1)) DUT (
      .clk_sys(clk_sys), .rstn(rstn), .dreq(dreq), .drdata(drdata),
      .drbit(drbit), .reg_space_sel(reg_space_sel), .reg_space_ok(reg_space_ok),
      .preq(preq), .prdata(prdata), .pwrite_done(pwrite_done),
      .prog_in_flash(prog_in_flash), .stack_pointer(stack_pointer),
      .active_bank(active_bank));
   core_model u_core (
      .clk_sys(clk_sys), .reg_space_sel(reg_space_sel), .reg_space_ok(reg_space_ok),
      .prog_in_flash(prog_in_flash), .dreq(dreq), .preq(preq));
   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 1000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys);
      rstn = 1'h1;
      check("ptr_reset", stack_pointer, 8'h07);
      u_core.acc(ACC_DIRECT, 1'h0, 1'h0, 8'h81, 8'h00, 1'h0);
      check("ptr_direct", drdata, 8'h07);
      check("reg_space_sel", u_core.sel_seen, 1'h1);
      u_core.acc(ACC_PUSH, 1'h1, 1'h0, 8'h00, 8'h55, 1'h0);
      check("ptr_push", stack_pointer, 8'h08);
      u_core.acc(ACC_DIRECT, 1'h0, 1'h0, 8'h08, 8'h00, 1'h0);
      check("push_byte", drdata, 8'h55);
      u_core.acc(ACC_POP, 1'h0, 1'h0, 8'h00, 8'h00, 1'h0);
      check("pop_data", drdata, 8'h55);
      check("ptr_pop", stack_pointer, 8'h07);
      u_core.acc(ACC_DIRECT, 1'h1, 1'h0, 8'hD0, 8'h18, 1'h0);
      check("bank", active_bank, 2'h3);
      // bank 3 index registers live at 0x18 and 0x19
      u_core.acc(ACC_DIRECT, 1'h1, 1'h0, 8'h18, 8'h81, 1'h0);
      u_core.acc(ACC_DIRECT, 1'h1, 1'h0, 8'h19, 8'h40, 1'h0);
      u_core.acc(ACC_INDIRECT, 1'h1, 1'h0, 8'h00, 8'hA5, 1'h0);
      check("ind_sel", u_core.sel_seen, 1'h0);
      u_core.acc(ACC_INDIRECT, 1'h1, 1'h1, 8'h00, 8'h3C, 1'h0);
      u_core.acc(ACC_DIRECT, 1'h0, 1'h0, 8'h81, 8'h00, 1'h0);
      check("regs_not_ram", drdata, 8'h07);
      u_core.acc(ACC_INDIRECT, 1'h0, 1'h0, 8'h00, 8'h00, 1'h0);
      check("upper_ram", drdata, 8'hA5);
      u_core.acc(ACC_DIRECT, 1'h0, 1'h0, 8'h40, 8'h00, 1'h0);
      check("lower_ram", drdata, 8'h3C);
      u_core.acc(ACC_DIRECT, 1'h1, 1'h0, 8'h22, 8'h00, 1'h0);
      u_core.acc(ACC_BIT, 1'h1, 1'h0, 8'h13, 8'h00, 1'h1);
      u_core.acc(ACC_DIRECT, 1'h0, 1'h0, 8'h22, 8'h00, 1'h0);
      check("bit_byte", drdata, 8'h08);
      u_core.acc(ACC_BIT, 1'h0, 1'h0, 8'h13, 8'h00, 1'h0);
      check("bit_read", drbit, 1'h1);
      // status word holds 0x18: clearing bit 4 leaves bank 1
      u_core.acc(ACC_BIT, 1'h1, 1'h0, 8'hD4, 8'h00, 1'h0);
      check("reg_bit", active_bank, 2'h1);
      check("bit_ok", u_core.ok_seen, 1'h1);
      u_core.acc(ACC_DIRECT, 1'h1, 1'h0, 8'h81, 8'hFE, 1'h0);
      u_core.acc(ACC_PUSH, 1'h1, 1'h0, 8'h00, 8'h77, 1'h0);
      check("ptr_top", stack_pointer, 8'hFF);
      u_core.acc(ACC_POP, 1'h0, 1'h0, 8'h00, 8'h00, 1'h0);
      check("pop_top", drdata, 8'h77);
      u_core.prog(1'h1, 1'h1, 16'h0010, 8'hAA);
      check("no_enable", pwrite_done, 1'h0);
      u_core.acc(ACC_DIRECT, 1'h1, 1'h0, 8'h8F, 8'h01, 1'h0);
      u_core.prog(1'h1, 1'h0, 16'h0010, 8'hAA);
      check("no_ext_move", pwrite_done, 1'h0);
      u_core.prog(1'h1, 1'h1, 16'h0010, 8'hAA);
      check("write_done", pwrite_done, 1'h1);
      u_core.prog(1'h0, 1'h0, 16'h0010, 8'h00);
      check("code_read", prdata, 8'hAA);
      check("in_flash", u_core.flash_seen, 1'h1);
      u_core.prog(1'h0, 1'h0, 16'h4000, 8'h00);
      check("outside", u_core.flash_seen, 1'h0);
      check("outside_data", prdata, 8'hFF);
      final_report();
   end
endmodule // cpu_memory_space_decoder_test
